// ===== include/sflo_params.svh
/*
 * Constants of the serial transfer engine: register offsets, field
 * positions, reset values and divider counts.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef SFLO_PARAMS_SVH
`define SFLO_PARAMS_SVH

// register offsets on the cpu register port
`define SFLO_ADDR_CTRL 16'h0010
`define SFLO_ADDR_STAT 16'h0011
`define SFLO_ADDR_DATA 16'h0012

// reset values: master role and clock phase 1 set out of reset
`define SFLO_CTRL_RST 8'h28
`define SFLO_CFG_RST 4'h0

// status register bit positions
`define SFLO_ST_RXF 7
`define SFLO_ST_ERROR_IRQ_ENABLE 6
`define SFLO_ST_OVR 5
`define SFLO_ST_ROLE_CONFLICT_FLAG 4
`define SFLO_ST_TXE 3
`define SFLO_ST_ROLE_CONFLICT_ENABLE 2

// half bit time in bus cycles, minus one, per rate select code
`define SFLO_HALF_DIV2 7'h00
`define SFLO_HALF_DIV8 7'h03
`define SFLO_HALF_DIV32 7'h0F
`define SFLO_HALF_DIV128 7'h3F

// serial clock edges and data bits in one transfer
`define SFLO_EDGES 5'h10
`define SFLO_BITS 4'h8
`define SFLO_LAST_BIT 4'h7
`define SFLO_BUF_FULL 2'h2

`endif

// ===== include/sflo_pkg.sv
/*
 * Types of the serial transfer engine: control and configuration
 * layouts and the master sequencer states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sflo_pkg;

	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic rx_ie;
		logic rsv;
		logic master;
		logic clock_idle_level_sel;
		logic clock_phase_sel;
		logic wired_or;
		logic en;
		logic tx_ie;
	} sflo_ctrl_t;

	// writable part of the status and control register
	typedef struct packed {
		logic error_irq_enable;
		logic role_conflict_enable;
		logic [1:0] rate;
	} sflo_cfg_t;

	// master sequencer
	typedef enum logic [1:0] {
		SFLO_IDLE = 2'b01,
		SFLO_RUN = 2'b10
	} sflo_state_t;

endpackage

// ===== rtl/sflo_core.sv
/*
 * Serial transfer engine: master or slave, both clock phases, a two-entry
 * transmit queue, overflow and role-conflict detection.
 * Assumes all inputs are synchronous to CLK and that pad logic resolves
 * the pins from the output enables.
 */
// Operation
// - slave drives its data output only while its select input is low
// - phase 0 captures MSB on first edge; select falling starts transfer
// - phase 1: first clock edge drives first bit and starts the transfer
// - master starts a transfer only after a data register write
// - phase 0 first half-bit idle; phase 1 bit period opens with edge
// - master divider runs freely only while enable and master role set
// - master clock edges reach the pin on the falling edge of the bus clock, at the start of its low time
// - write-to-start delay is at most one bit time
// - unread receive data at first capture sets overflow, drops new byte
// - overflow and role conflict share one error interrupt enable
// - select level conflicting with the role sets role conflict flag
// - no receive-full interrupt while overflow stays set
// - enabled overflow interrupt can wake the processor from wait
// - receive full clears by status read then data read
// - polarity picks only the clock idle level
`include "sflo_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sflo_core
	import sflo_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// cpu register port
	input wire logic [15:0] ADDR,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	output logic TX_READY,
	output logic IRQ_RX_ERR,
	// serial pins
	input wire logic SCLK_IN,
	output logic SCLK_OUT,
	output logic SCLK_OE,
	input wire logic SS_N_IN,
	input wire logic MOSI_IN,
	output logic MOSI_OUT,
	output logic MOSI_OE,
	input wire logic MISO_IN,
	output logic MISO_OUT,
	output logic MISO_OE
);

	sflo_ctrl_t ctrl_q;
	sflo_cfg_t cfg_q;
	sflo_state_t st_q;
	logic [7:0] buf_q [0:1];
	logic wp_q, rp_q;
	logic [1:0] cnt_q, cnt_d;
	logic [6:0] div_q, half_m1;
	logic [4:0] edge_q;
	logic [3:0] ei, bit_cnt_q;
	logic sck_q, sck_neg_q, sck_prev_q, ss_prev_q, slv_busy_q, s_loaded_q;
	logic [7:0] tx_sh_q, rx_sh_q, rx_data_q, rdata_q;
	logic sdo_q, drop_q, rx_full_q, ovr_q, role_conflict_flag_q;
	logic arm_rx_q, arm_ovr_q, arm_role_conflict_flag_q;
	logic irq_q, tx_ready_q, sck_oe_q, mosi_oe_q, miso_oe_q;
	logic mst_on, slv_on, wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
	logic push, pop, tx_valid, tick, fault_m, load_m, load_s, m_edge, m_go;
	logic s_lead, s_trail, s_start, s_start0, lead, trail, samp, shft;
	logic sdi, store, ovr_set, role_conflict_flag_set, done_s;

	// decode and shared strobes
	assign mst_on = ctrl_q.en & ctrl_q.master;
	assign slv_on = ctrl_q.en & ~ctrl_q.master;
	assign wr_ctrl = WR_EN && (ADDR == `SFLO_ADDR_CTRL);
	assign wr_stat = WR_EN && (ADDR == `SFLO_ADDR_STAT);
	assign wr_data = WR_EN && (ADDR == `SFLO_ADDR_DATA);
	assign rd_stat = RD_EN && (ADDR == `SFLO_ADDR_STAT);
	assign rd_data = RD_EN && (ADDR == `SFLO_ADDR_DATA);
	assign tx_valid = (cnt_q != 2'h0);
	assign push = wr_data & ctrl_q.en & (cnt_q != `SFLO_BUF_FULL);
	assign tick = (div_q == half_m1);
	assign fault_m = mst_on & cfg_q.role_conflict_enable & ~SS_N_IN;
	// master loads only queued bytes, on a divider tick
	assign load_m = mst_on & (st_q == SFLO_IDLE) & tick & tx_valid & ~fault_m;
	assign load_s = slv_on & ~slv_busy_q & ~s_loaded_q & tx_valid;
	assign pop = load_m | load_s;
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	assign m_edge = (st_q == SFLO_RUN) & tick & (edge_q != `SFLO_EDGES);
	assign m_go = m_edge | (load_m & ctrl_q.clock_phase_sel);
	assign ei = load_m ? 4'h0 : edge_q[3:0];
	// slave edges are ignored while deselected
	assign s_lead = slv_on & ~SS_N_IN & (sck_prev_q == ctrl_q.clock_idle_level_sel) & (SCLK_IN != ctrl_q.clock_idle_level_sel);
	assign s_trail = slv_on & ~SS_N_IN & (sck_prev_q != ctrl_q.clock_idle_level_sel) & (SCLK_IN == ctrl_q.clock_idle_level_sel);
	assign s_start0 = slv_on & ~ctrl_q.clock_phase_sel & ss_prev_q & ~SS_N_IN;
	assign s_start = s_start0 | (ctrl_q.clock_phase_sel & s_lead & ~slv_busy_q);
	assign lead = (m_go & ~ei[0]) | s_lead;
	assign trail = (m_go & ei[0]) | s_trail;
	// phase picks which edge samples and which shifts
	assign samp = ctrl_q.clock_phase_sel ? trail : lead;
	assign shft = (ctrl_q.clock_phase_sel ? lead : (trail & (bit_cnt_q != `SFLO_BITS)))
		| s_start0 | (load_m & ~ctrl_q.clock_phase_sel);
	assign sdi = ctrl_q.master ? MISO_IN : MOSI_IN;
	assign store = samp && (bit_cnt_q == `SFLO_LAST_BIT) && !drop_q && !ovr_q;
	assign ovr_set = samp && (bit_cnt_q == 4'h0) && rx_full_q;
	assign done_s = s_trail & (bit_cnt_q == (ctrl_q.clock_phase_sel ? `SFLO_LAST_BIT : `SFLO_BITS));
	assign role_conflict_flag_set = cfg_q.role_conflict_enable & (fault_m | (slv_on & slv_busy_q & SS_N_IN));

	// half bit count per rate select
	always_comb
	begin
		case (cfg_q.rate)
			2'h0: half_m1 = `SFLO_HALF_DIV2;
			2'h1: half_m1 = `SFLO_HALF_DIV8;
			2'h2: half_m1 = `SFLO_HALF_DIV32;
			default: half_m1 = `SFLO_HALF_DIV128;
		endcase
	end

	// control register; a master role conflict drops the enable
	always_ff @(posedge CLK)
	begin
		if (RST)
			ctrl_q <= `SFLO_CTRL_RST;
		else if (fault_m)
			ctrl_q.en <= 1'b0;
		else if (wr_ctrl)
			ctrl_q <= WDATA & 8'hBF;
	end

	// configuration bits of the status register
	always_ff @(posedge CLK)
	begin
		if (RST)
			cfg_q <= `SFLO_CFG_RST;
		else if (wr_stat)
			cfg_q <= {WDATA[`SFLO_ST_ERROR_IRQ_ENABLE], WDATA[`SFLO_ST_ROLE_CONFLICT_ENABLE], WDATA[1:0]};
	end

	// two-entry transmit queue; full stalls the writer through TX_READY
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_ent
			always_ff @(posedge CLK)
			begin
				if (push && (wp_q == 1'(g)))
					buf_q[g] <= WDATA;
			end
		end
	endgenerate

	always_ff @(posedge CLK)
	begin
		if (RST || !ctrl_q.en)
		begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			wp_q <= wp_q ^ push;
			rp_q <= rp_q ^ pop;
			cnt_q <= cnt_d;
		end
	end

	// free-running divider, held at zero unless enabled master
	always_ff @(posedge CLK)
	begin
		if (RST || !mst_on || tick)
			div_q <= 7'h00;
		else
			div_q <= div_q + 7'h01;
	end

	// master sequencer and serial clock level
	always_ff @(posedge CLK)
	begin
		if (RST || !mst_on || fault_m)
		begin
			st_q <= SFLO_IDLE;
			edge_q <= 5'h00;
			sck_q <= ctrl_q.clock_idle_level_sel;
		end
		else
		begin
			case (st_q)
				SFLO_IDLE:
				begin
					sck_q <= ctrl_q.clock_idle_level_sel;
					if (load_m)
					begin
						st_q <= SFLO_RUN;
						edge_q <= ctrl_q.clock_phase_sel ? 5'h01 : 5'h00;
						if (ctrl_q.clock_phase_sel)
							sck_q <= ~ctrl_q.clock_idle_level_sel;
					end
				end
				SFLO_RUN:
				begin
					if (tick && edge_q == `SFLO_EDGES)
						st_q <= SFLO_IDLE;
					else if (tick)
					begin
						sck_q <= ~sck_q;
						edge_q <= edge_q + 5'h01;
					end
				end
				default: st_q <= SFLO_IDLE;
			endcase
		end
	end

	// clock pin changes in the low half of the bus clock
	always_ff @(negedge CLK)
	begin
		if (RST)
			sck_neg_q <= 1'b0;
		else
			sck_neg_q <= sck_q;
	end

	// slave framing: start, end and whether a fresh byte is loaded
	always_ff @(posedge CLK)
	begin
		if (RST || !slv_on)
		begin
			slv_busy_q <= 1'b0;
			s_loaded_q <= 1'b0;
			sck_prev_q <= 1'b0;
			ss_prev_q <= 1'b1;
		end
		else
		begin
			sck_prev_q <= SCLK_IN;
			ss_prev_q <= SS_N_IN;
			// deselect ends a frame; phase 0 needs it between bytes
			if (SS_N_IN || done_s)
				slv_busy_q <= 1'b0;
			else if (s_start)
				slv_busy_q <= 1'b1;
			if (s_start)
				s_loaded_q <= 1'b0;
			else if (load_s)
				s_loaded_q <= 1'b1;
		end
	end

	// transmit shifter; unloaded slave shifts out the zeros left in the shifter
	always_ff @(posedge CLK)
	begin
		if (RST || !ctrl_q.en)
		begin
			tx_sh_q <= 8'h00;
			sdo_q <= 1'b0;
		end
		else if (pop && shft)
		begin
			sdo_q <= buf_q[rp_q][7];
			tx_sh_q <= {buf_q[rp_q][6:0], 1'b0};
		end
		else if (pop)
			tx_sh_q <= buf_q[rp_q];
		else if (shft)
		begin
			sdo_q <= tx_sh_q[7];
			tx_sh_q <= {tx_sh_q[6:0], 1'b0};
		end
	end

	// receive shifter; a byte is marked for dropping at its first capture
	always_ff @(posedge CLK)
	begin
		if (RST || !ctrl_q.en || load_m || s_start || (slv_on && SS_N_IN))
		begin
			bit_cnt_q <= 4'h0;
			drop_q <= 1'b0;
		end
		else if (samp)
		begin
			rx_sh_q <= {rx_sh_q[6:0], sdi};
			bit_cnt_q <= bit_cnt_q + 4'h1;
			if (bit_cnt_q == 4'h0)
				drop_q <= rx_full_q | ovr_q;
		end
	end

	// receive register keeps the unread byte on overflow
	always_ff @(posedge CLK)
	begin
		if (store)
			rx_data_q <= {rx_sh_q[6:0], sdi};
	end

	// read arming for the two-step clears
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			arm_rx_q <= 1'b0;
			arm_ovr_q <= 1'b0;
			arm_role_conflict_flag_q <= 1'b0;
		end
		else
		begin
			if (rd_stat)
			begin
				arm_rx_q <= rx_full_q;
				arm_ovr_q <= ovr_q;
				arm_role_conflict_flag_q <= role_conflict_flag_q;
			end
			else
			begin
				if (rd_data)
					arm_rx_q <= 1'b0;
				if (rd_data)
					arm_ovr_q <= 1'b0;
				if (wr_ctrl)
					arm_role_conflict_flag_q <= 1'b0;
			end
		end
	end

	// status flags: a set in the clearing cycle wins
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rx_full_q <= 1'b0;
			ovr_q <= 1'b0;
			role_conflict_flag_q <= 1'b0;
		end
		else
		begin
			rx_full_q <= store | (rx_full_q & ~(rd_data & arm_rx_q));
			ovr_q <= ovr_set | (ovr_q & ~(rd_data & arm_ovr_q));
			role_conflict_flag_q <= role_conflict_flag_set | (role_conflict_flag_q & ~(wr_ctrl & arm_role_conflict_flag_q));
		end
	end

	// registered outputs: read data, interrupt, pin enables
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
			tx_ready_q <= 1'b0;
			sck_oe_q <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end
		else
		begin
			if (RD_EN)
			begin
				case (ADDR)
					`SFLO_ADDR_CTRL: rdata_q <= ctrl_q;
					`SFLO_ADDR_STAT: rdata_q <= {rx_full_q, cfg_q.error_irq_enable, ovr_q, role_conflict_flag_q,
						cnt_q != `SFLO_BUF_FULL, cfg_q.role_conflict_enable, cfg_q.rate};
					`SFLO_ADDR_DATA: rdata_q <= rx_data_q;
					default: rdata_q <= 8'h00;
				endcase
			end
			// one line serves receive, errors and wakeup
			irq_q <= (cfg_q.error_irq_enable & (ovr_q | role_conflict_flag_q))
				| (ctrl_q.rx_ie & ctrl_q.en & rx_full_q & ~ovr_q);
			tx_ready_q <= ctrl_q.en & (cnt_d != `SFLO_BUF_FULL);
			sck_oe_q <= mst_on & ~fault_m;
			mosi_oe_q <= mst_on & ~fault_m;
			miso_oe_q <= slv_on & ~SS_N_IN;
		end
	end

	assign RDATA = rdata_q;
	assign IRQ_RX_ERR = irq_q;
	assign TX_READY = tx_ready_q;
	assign SCLK_OUT = sck_neg_q;
	assign SCLK_OE = sck_oe_q;
	assign MOSI_OUT = sdo_q;
	assign MOSI_OE = mosi_oe_q;
	assign MISO_OUT = sdo_q;
	assign MISO_OE = miso_oe_q;

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	miso_drive_a: assert property (MISO_OE |-> !$past(SS_N_IN))
		else $error("slave output driven while deselected");
	div_hold_a: assert property (!mst_on |=> div_q == 7'h00)
		else $error("divider ran outside master mode");
	start_write_a: assert property ((st_q == SFLO_IDLE) && !tx_valid |=> st_q == SFLO_IDLE)
		else $error("master started without queued byte");
	start_lat_a: assert property ((st_q == SFLO_IDLE) && tx_valid && mst_on && !fault_m
		|-> ##[0:64] (load_m || !mst_on || fault_m))
		else $error("start delay exceeded one bit time");
	ph0_idle_a: assert property (load_m && !ctrl_q.clock_phase_sel |=> sck_q == $past(ctrl_q.clock_idle_level_sel))
		else $error("phase 0 clock left idle on load");
	ph1_edge_a: assert property (load_m && ctrl_q.clock_phase_sel |=> sck_q != $past(ctrl_q.clock_idle_level_sel))
		else $error("phase 1 lacks opening edge");
	ovr_set_a: assert property (ovr_set && !load_m && !s_start |=> ovr_q && drop_q)
		else $error("overflow not flagged");
	role_fault_a: assert property (fault_m |=> role_conflict_flag_q && !ctrl_q.en && !SCLK_OE)
		else $error("master role conflict not handled");
	rx_irq_mask_a: assert property (ovr_q && !cfg_q.error_irq_enable |=> !IRQ_RX_ERR)
		else $error("receive interrupt while overflow set");
	rxf_clear_a: assert property (rd_data && arm_rx_q && !store |=> !rx_full_q)
		else $error("receive full not cleared");

endmodule // sflo_core

`default_nettype wire

// ===== sim/sflo_slave_model.sv
/*
 * Slave partner on the serial link: eight bits msb first, either phase.
 * Assumes sck rests at the idle level while the select line is high.
 */
`timescale 1ns/1ps
`default_nettype none

module sflo_slave_model
(
	// link pins
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// format and data
	input wire logic clock_phase_sel,
	input wire logic clock_idle_level_sel,
	input wire logic [7:0] tx,
	output logic [7:0] rx
);
	logic [7:0] sh;

	initial miso = 1'b0;

	// select fall loads the byte; phase 0 shows the msb before any edge
	always @(negedge ss_n)
	begin
		sh = tx;
		if (!clock_phase_sel)
		begin
			miso = sh[7];
			sh = {sh[6:0], 1'b0};
		end
	end

	// a released line shows the inverse, so a stale bit never passes
	always @(posedge ss_n) miso = ~miso;

	// drive edge is the leading one in phase 1, the trailing one in phase 0
	always @(sck)
		if (!ss_n)
		begin
			if ((sck != clock_idle_level_sel) == clock_phase_sel)
			begin
				miso = sh[7];
				sh = {sh[6:0], 1'b0};
			end
			else
				rx = {rx[6:0], mosi};
		end
endmodule // sflo_slave_model

`default_nettype wire

// ===== sim/spi_format_latency_overflow_tb_top.sv
/*
 * Testbench of the serial transfer engine: register tasks, partner slave.
 * Assumes the package, the constants header and the partner model.
 */
`include "sflo_params.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_format_latency_overflow_tb_top;
	import sflo_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic ss_n = 1'b1;
	logic sel_n = 1'b1;
	logic clock_phase_sel = 1'b0;
	logic clock_idle_level_sel = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] slv_tx = 8'h00;
	logic [7:0] rdata, slv_rx, got;
	logic tx_ready, irq, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, miso, sck, mosi;
	logic first_mosi;
	int bad_count = 0;
	int comparisons = 0;
	int edges = 0;
	int n;

	always #2.5 clk = ~clk;

	// undriven link lines rest at their idle or pulled level
	assign sck = sclk_oe ? sclk_out : clock_idle_level_sel;
	assign mosi = mosi_oe ? mosi_out : 1'b1;
	// data line as the first clock edge of a transfer leaves the pin
	always @(sclk_out)
	begin
		if (edges == 0)
			first_mosi = mosi;
		edges++;
	end

	sflo_core sflo_core_inst (.CLK(clk), .RST(rst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
		.WDATA(wdata), .RDATA(rdata), .TX_READY(tx_ready), .IRQ_RX_ERR(irq), .SCLK_IN(sck),
		.SCLK_OUT(sclk_out), .SCLK_OE(sclk_oe), .SS_N_IN(ss_n), .MOSI_IN(mosi),
		.MOSI_OUT(mosi_out), .MOSI_OE(mosi_oe), .MISO_IN(miso), .MISO_OUT(miso_out),
		.MISO_OE(miso_oe));
	sflo_slave_model sflo_slave_model_inst (.sck(sck), .ss_n(sel_n), .mosi(mosi), .miso(miso),
		.clock_phase_sel(clock_phase_sel), .clock_idle_level_sel(clock_idle_level_sel), .tx(slv_tx), .rx(slv_rx));

	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
	begin
		comparisons++;
		if (act !== exp)
			$display("ERROR at %0t: got %h expected %h (mismatch %0d)", $time, act, exp, ++bad_count);
	end
	endtask

	// strobes rise and fall on falling clock edges, one cycle wide
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		got = rdata;
	endtask

	// one master byte with the partner selected; rdout also reads it back
	task automatic xfer(input logic [7:0] mo, input logic [7:0] si, input logic rdout);
		slv_tx = si;
		sel_n = 1'b0;
		edges = 0;
		wr(`SFLO_ADDR_DATA, mo);
		for (n = 0; sclk_out === clock_idle_level_sel && n < 8; n++)
			@(negedge clk);
		chk({7'h00, n <= 3}, 8'h01);
		chk({7'h00, first_mosi}, {7'h00, mo[7]});
		for (n = 0; edges < 16 && n < 100; n++)
			@(negedge clk);
		repeat (4) @(negedge clk);
		chk({7'h00, tx_ready}, 8'h01);
		chk({7'h00, mosi_oe}, 8'h01);
		chk(8'(edges), 8'h10);
		chk(slv_rx, mo);
		chk({7'h00, sclk_out}, {7'h00, clock_idle_level_sel});
		sel_n = 1'b1;
		if (rdout)
		begin
			rd(`SFLO_ADDR_STAT);
			chk(got & 8'hA0, 8'h80);
			chk({7'h00, irq}, 8'h01);
			rd(`SFLO_ADDR_DATA);
			chk(got, si);
			rd(`SFLO_ADDR_STAT);
			chk(got & 8'h80, 8'h00);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a few hundred cycles suffice; this only cuts a hang short
	initial
	begin
		#100000;
		$display("ERROR at %0t: watchdog expired (mismatch %0d)", $time, ++bad_count);
		final_report;
	end

	initial
	begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		rd(`SFLO_ADDR_CTRL);
		chk(got, `SFLO_CTRL_RST);
		// master role without enable: divider and clock pin stay quiet
		wr(`SFLO_ADDR_CTRL, 8'h20);
		edges = 0;
		repeat (8) @(negedge clk);
		chk({7'h00, sclk_oe}, 8'h00);
		chk(8'(edges), 8'h00);
		// every phase and polarity, disabling before each format change
		for (int m = 0; m < 4; m++)
		begin
			clock_phase_sel = m[0];
			clock_idle_level_sel = m[1];
			wr(`SFLO_ADDR_CTRL, 8'h20);
			wr(`SFLO_ADDR_CTRL, 8'hA2 | {3'h0, m[1:0], 3'h0});
			// the pin settles at its new idle level before the partner is selected
			repeat (2) @(negedge clk);
			xfer(8'hA5 ^ 8'(m), 8'h3C + 8'(m), 1'b1);
		end
		// two unread bytes: the second is dropped and the first survives
		xfer(8'h11, 8'h81, 1'b0);
		xfer(8'h22, 8'h82, 1'b0);
		rd(`SFLO_ADDR_STAT);
		chk(got & 8'hA0, 8'hA0);
		chk({7'h00, irq}, 8'h00);
		wr(`SFLO_ADDR_STAT, 8'h40);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		rd(`SFLO_ADDR_STAT);
		rd(`SFLO_ADDR_DATA);
		chk(got, 8'h81);
		rd(`SFLO_ADDR_STAT);
		chk(got & 8'hA0, 8'h00);
		chk({7'h00, irq}, 8'h00);
		// own select pulled low in master role with fault detection on
		wr(`SFLO_ADDR_STAT, 8'h04);
		ss_n = 1'b0;
		repeat (3) @(negedge clk);
		ss_n = 1'b1;
		rd(`SFLO_ADDR_STAT);
		chk(got & 8'h10, 8'h10);
		rd(`SFLO_ADDR_CTRL);
		chk(got, 8'hB8);
		// slave role: data output enabled only while selected
		wr(`SFLO_ADDR_CTRL, 8'h02);
		wr(`SFLO_ADDR_DATA, 8'h80);
		repeat (3) @(negedge clk);
		chk({7'h00, miso_oe}, 8'h00);
		ss_n = 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h00, miso_oe}, 8'h01);
		chk({7'h00, miso_out}, 8'h01);
		ss_n = 1'b1;
		repeat (3) @(negedge clk);
		chk({7'h00, miso_oe}, 8'h00);
		final_report;
	end
endmodule // spi_format_latency_overflow_tb_top

`default_nettype wire
